// >>> core/vsd_slave.sv
// Overview of operation
// - a32 mode decodes one aligned 16MB window
// - upper two switches give base bits 31:24
// - a24 mode decodes one aligned 4MB window
// - a24 mode ignores the two upper switches
// - low switch 0-3 gives a24 bits 23:22
// - writes posted: acked once queued, memory later
// - sequential reads prefetch the next memory word
// - a24/a32 cycles, d32/d16/d08 transfers accepted
// - 4MB memory shared with local processor port
// - a32 address regions swap bytes or halfwords; a24 never swaps
// - enable switch on means all cycles ignored
// - 8 base bits select one of 256 windows
// - byte offset 3 reaches least significant byte
`timescale 1ns/1ps
module vsd_slave #(
  parameter int FIFO_DEPTH = vsd_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] base_switch_high,
  input wire logic [3:0] base_switch_mid,
  input wire logic [3:0] base_switch_low,
  input wire logic slave_port_enable_switch,
  output logic a32_mode,
  input wire logic bus_req_valid,
  output logic bus_req_ready,
  input wire logic bus_am32,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic mem_write,
  output logic [vsd_pkg::MEM_AW-1:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic loc_req_valid,
  output logic loc_req_ready,
  input wire logic loc_write,
  input wire logic [vsd_pkg::MEM_AW-1:0] loc_addr,
  input wire logic [3:0] loc_be,
  input wire logic [31:0] loc_wdata,
  output logic loc_rvalid,
  output logic [31:0] loc_rdata
);
  localparam int AW = vsd_pkg::MEM_AW;
  localparam logic [AW-1:0] TOP_WORD = '1;

  logic [12:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_r;
  logic en, hit, pf_hit, fire, rd_fire, wr_fire;
  logic [7:0] base32;
  logic [1:0] req_swap;
  logic [4:0] req_sh;
  logic [31:0] req_mask;
  logic [AW-1:0] req_word;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [vsd_pkg::FIFO_W-1:0] fifo_in_data, fifo_out_data;
  logic [3:0] wr_be;
  vsd_pkg::vsd_state_t state_r;
  logic [1:0] cur_swap_r;
  logic [4:0] cur_sh_r;
  logic [31:0] cur_mask_r;
  logic [AW-1:0] cur_word_r, pf_word_r;
  logic [31:0] pf_data_r;
  logic pf_valid_r, rd_busy_r, own_loc_r, rr_r;
  logic eng_rd, slv_cand, gnt_loc, issue, slv_rdata;

  // switch pins: three stages, accept once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_s1_r <= vsd_pkg::SW_RST;
      sw_s2_r <= vsd_pkg::SW_RST;
      sw_s3_r <= vsd_pkg::SW_RST;
      sw_r <= vsd_pkg::SW_RST;
    end else begin
      sw_s1_r <= {slave_port_enable_switch, base_switch_low,
                  base_switch_mid, base_switch_high};
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
      if (sw_s2_r == sw_s3_r) begin
        sw_r <= sw_s3_r;
      end
    end
  end

  assign en = !sw_r[12];
  assign a32_mode = sw_r[11:8] > vsd_pkg::MODE24_MAX;
  assign base32 = {sw_r[3:0], sw_r[7:4]};
  // a24 compare uses only the low switch
  assign hit = en && (bus_size != vsd_pkg::SZ_BAD) && (a32_mode ?
    (bus_am32 && bus_addr[31:vsd_pkg::A32_BASE_LSB] == base32) :
    (!bus_am32 && bus_addr[23:vsd_pkg::A24_BASE_LSB] == sw_r[9:8]));
  assign req_word = bus_addr[vsd_pkg::WORD_LSB +: AW];
  assign req_swap = a32_mode ? bus_addr[vsd_pkg::SWAP_LSB +: 2]
                             : vsd_pkg::SWP_NONE;
  assign req_sh = vsd_pkg::lane_shift(bus_size, bus_addr[1:0]);
  assign req_mask = vsd_pkg::data_mask(bus_size);
  assign wr_be = vsd_pkg::swap_be(4'((req_mask[3:0] == 4'hF ?
    ({req_mask[24], req_mask[16], req_mask[8], req_mask[0]}) : 4'h1)
    << req_sh[4:3]), req_swap);
  assign fifo_in_data = {req_word, wr_be,
    vsd_pkg::swap_word((bus_wdata & req_mask) << req_sh, req_swap)};
  assign pf_hit = pf_valid_r && (pf_word_r == req_word);

  // reads wait for posted writes so they never overtake them
  assign bus_req_ready = (state_r == vsd_pkg::ST_IDLE) && (!hit ||
    (bus_write ? fifo_in_ready : !fifo_out_valid));
  assign fire = bus_req_valid && bus_req_ready;
  assign wr_fire = fire && hit && bus_write;
  assign rd_fire = fire && hit && !bus_write;

  vsd_fifo #(.WIDTH(vsd_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_post (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(wr_fire),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // shared memory arbiter, round robin, one read outstanding
  assign eng_rd = (state_r == vsd_pkg::ST_RD_REQ) ||
                  (state_r == vsd_pkg::ST_PF_REQ);
  assign slv_cand = eng_rd || fifo_out_valid;
  assign gnt_loc = loc_req_valid && (!slv_cand || rr_r);
  assign mem_req_valid = !rd_busy_r && (slv_cand || loc_req_valid);
  assign issue = mem_req_valid && mem_req_ready;
  assign loc_req_ready = gnt_loc && !rd_busy_r && mem_req_ready;
  assign fifo_out_ready = issue && !gnt_loc && !eng_rd;
  assign slv_rdata = mem_rvalid && !own_loc_r;

  always_comb begin
    mem_write = 1'b0;
    mem_addr = (state_r == vsd_pkg::ST_PF_REQ) ? pf_word_r : cur_word_r;
    mem_be = 4'hF;
    mem_wdata = loc_wdata;
    if (gnt_loc) begin
      mem_write = loc_write;
      mem_addr = loc_addr;
      mem_be = loc_be;
    end else if (!eng_rd) begin
      mem_write = 1'b1;
      {mem_addr, mem_be, mem_wdata} = fifo_out_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_busy_r <= 1'b0;
      own_loc_r <= 1'b0;
      rr_r <= 1'b0;
      loc_rvalid <= 1'b0;
      loc_rdata <= 32'h0000_0000;
    end else begin
      if (issue) begin
        rr_r <= !gnt_loc;
      end
      if (issue && !mem_write) begin
        rd_busy_r <= 1'b1;
        own_loc_r <= gnt_loc;
      end else if (mem_rvalid) begin
        rd_busy_r <= 1'b0;
      end
      loc_rvalid <= mem_rvalid && own_loc_r;
      if (mem_rvalid && own_loc_r) begin
        loc_rdata <= mem_rdata;
      end
    end
  end

  // read engine with one word of prefetch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= vsd_pkg::ST_IDLE;
      cur_swap_r <= vsd_pkg::SWP_NONE;
      cur_sh_r <= 5'h00;
      cur_mask_r <= 32'h0000_0000;
      cur_word_r <= '0;
      pf_word_r <= '0;
      pf_data_r <= 32'h0000_0000;
      pf_valid_r <= 1'b0;
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_ack <= wr_fire || (rd_fire && pf_hit) ||
                 (state_r == vsd_pkg::ST_RD_WAIT && slv_rdata);
      if (wr_fire || (issue && gnt_loc && loc_write &&
                      loc_addr == pf_word_r)) begin
        pf_valid_r <= 1'b0;
      end
      unique case (state_r)
        vsd_pkg::ST_IDLE: begin
          if (rd_fire) begin
            cur_swap_r <= req_swap;
            cur_sh_r <= req_sh;
            cur_mask_r <= req_mask;
            cur_word_r <= req_word;
            if (pf_hit) begin
              bus_rdata <= (vsd_pkg::swap_word(pf_data_r, req_swap)
                            >> req_sh) & req_mask;
              pf_valid_r <= 1'b0;
              pf_word_r <= req_word + 1'b1;
              state_r <= (req_word == TOP_WORD) ? vsd_pkg::ST_IDLE
                                                : vsd_pkg::ST_PF_REQ;
            end else begin
              state_r <= vsd_pkg::ST_RD_REQ;
            end
          end
        end
        vsd_pkg::ST_RD_REQ: begin
          if (issue && !gnt_loc) begin
            state_r <= vsd_pkg::ST_RD_WAIT;
          end
        end
        vsd_pkg::ST_RD_WAIT: begin
          if (slv_rdata) begin
            bus_rdata <= (vsd_pkg::swap_word(mem_rdata, cur_swap_r)
                          >> cur_sh_r) & cur_mask_r;
            pf_valid_r <= 1'b0;
            pf_word_r <= cur_word_r + 1'b1;
            state_r <= (cur_word_r == TOP_WORD) ? vsd_pkg::ST_IDLE
                                                : vsd_pkg::ST_PF_REQ;
          end
        end
        vsd_pkg::ST_PF_REQ: begin
          if (issue && !gnt_loc) begin
            state_r <= vsd_pkg::ST_PF_WAIT;
          end
        end
        vsd_pkg::ST_PF_WAIT: begin
          if (slv_rdata) begin
            pf_data_r <= mem_rdata;
            pf_valid_r <= 1'b1;
            state_r <= vsd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_demand_done;
    state_r == vsd_pkg::ST_RD_WAIT && slv_rdata;
  endsequence

  a_a32_window: assert property (wr_fire && a32_mode |->
    bus_am32 && bus_addr[31:24] == {sw_r[3:0], sw_r[7:4]} ##1 bus_ack)
    else $error("a32 write outside window or not acked");
  a_a24_window: assert property (bus_req_valid && bus_req_ready && en &&
    !a32_mode && !bus_am32 && bus_write && bus_size != 2'h3 &&
    bus_addr[23:22] == sw_r[9:8] |=> bus_ack)
    else $error("a24 write in window not acked");
  a_mode_pick: assert property (fire && bus_am32 &&
    sw_r[11:8] <= 4'h3 |=> !bus_ack)
    else $error("a32 cycle answered in a24 mode");
  a_disabled_quiet: assert property (sw_r[12] throughout
    (fire ##1 1'b1) |-> !bus_ack)
    else $error("cycle answered while disabled");
  a_post_stall: assert property (!fifo_in_ready && bus_write && hit
    |-> !bus_req_ready)
    else $error("write taken while post fifo full");
  a_pf_follows: assert property (s_demand_done and
    (cur_word_r != TOP_WORD) |=>
    state_r == vsd_pkg::ST_PF_REQ ##[1:64] pf_valid_r)
    else $error("no prefetch after read");
  a_pf_fast: assert property (rd_fire && pf_hit |=> bus_ack &&
    bus_rdata == $past(vsd_pkg::swap_word(pf_data_r, req_swap) >> req_sh
    & req_mask))
    else $error("prefetch hit not answered at once");
  a_byte_lane: assert property (wr_fire && bus_size == vsd_pkg::SZ_D08 &&
    bus_addr[1:0] == 2'h3 && req_swap == vsd_pkg::SWP_NONE |->
    wr_be == 4'h1 && fifo_in_data[7:0] == bus_wdata[7:0])
    else $error("offset three not in lowest lane");
  a_full_swap: assert property (wr_fire && req_swap == vsd_pkg::SWP_FULL &&
    bus_size == vsd_pkg::SZ_D32 |-> fifo_in_data[31:0] ==
    {bus_wdata[7:0], bus_wdata[15:8], bus_wdata[23:16],
    bus_wdata[31:24]})
    else $error("full swap region wrong");
  a_loc_served: assert property (loc_req_valid && !rd_busy_r &&
    mem_req_ready && rr_r |-> loc_req_ready)
    else $error("local port starved on its turn");
endmodule

// >>> core/vsd_pkg.sv
package vsd_pkg;
  localparam int MEM_AW = 20;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = MEM_AW + 4 + 32;
  localparam int A32_BASE_LSB = 24;
  localparam int A24_BASE_LSB = 22;
  localparam int SWAP_LSB = 22;
  localparam int WORD_LSB = 2;
  localparam logic [3:0] MODE24_MAX = 4'h3;
  localparam logic [12:0] SW_RST = 13'h1000;
  localparam logic [1:0] SZ_D32 = 2'h0;
  localparam logic [1:0] SZ_D16 = 2'h1;
  localparam logic [1:0] SZ_D08 = 2'h2;
  localparam logic [1:0] SZ_BAD = 2'h3;
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_BYTE = 2'h1;
  localparam logic [1:0] SWP_HALF = 2'h2;
  localparam logic [1:0] SWP_FULL = 2'h3;

  typedef enum {ST_IDLE, ST_RD_REQ, ST_RD_WAIT, ST_PF_REQ, ST_PF_WAIT}
    vsd_state_t;

  function automatic logic [31:0] swap_word(input logic [31:0] d,
                                            input logic [1:0] m);
    logic [31:0] r;
    r = d;
    case (m)
      SWP_NONE: r = d;
      SWP_BYTE: r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      SWP_HALF: r = {d[15:0], d[31:16]};
      SWP_FULL: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endcase
    return r;
  endfunction

  function automatic logic [3:0] swap_be(input logic [3:0] b,
                                         input logic [1:0] m);
    logic [3:0] r;
    r = b;
    case (m)
      SWP_NONE: r = b;
      SWP_BYTE: r = {b[2], b[3], b[0], b[1]};
      SWP_HALF: r = {b[1:0], b[3:2]};
      SWP_FULL: r = {b[0], b[1], b[2], b[3]};
    endcase
    return r;
  endfunction

  // byte offset k sits in lane 3-k; narrow data is right-justified
  function automatic logic [4:0] lane_shift(input logic [1:0] sz,
                                            input logic [1:0] a);
    logic [4:0] r;
    r = 5'h00;
    case (sz)
      SZ_D16: r = a[1] ? 5'h00 : 5'h10;
      SZ_D08: r = {~a, 3'h0};
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] data_mask(input logic [1:0] sz);
    logic [31:0] r;
    r = 32'hFFFF_FFFF;
    case (sz)
      SZ_D16: r = 32'h0000_FFFF;
      SZ_D08: r = 32'h0000_00FF;
      default: r = 32'hFFFF_FFFF;
    endcase
    return r;
  endfunction
endpackage

// >>> core/vsd_fifo.sv
`timescale 1ns/1ps
module vsd_fifo #(
  parameter int WIDTH = vsd_pkg::FIFO_W,
  parameter int DEPTH = vsd_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wptr_r, rptr_r;
  logic [PW:0] cnt_r;
  logic in_fire, load, take, bypass;

  assign in_ready = cnt_r < (PW+1)'(DEPTH);
  assign in_fire = in_valid && in_ready;
  assign load = !out_valid || out_ready;
  assign take = load && (cnt_r != '0);
  assign bypass = load && (cnt_r == '0) && in_fire;

  always_ff @(posedge ref_clk) begin
    if (in_fire && !bypass) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (in_fire && !bypass) begin
        wptr_r <= (wptr_r == PW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (take) begin
        rptr_r <= (rptr_r == PW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(in_fire && !bypass) - (PW+1)'(take);
    end
  end

  // head word held in a register so the reader sees flop outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= take || bypass;
      if (take) begin
        out_data <= mem_r[rptr_r];
      end else if (bypass) begin
        out_data <= in_data;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_r <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// >>> dv/vsd_mem_model.sv
`timescale 1ns/1ps
module vsd_mem_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [3:0] rd_lat,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic mem_write,
  input wire logic [vsd_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [vsd_pkg::MEM_AW-1:0]];
  logic pend_r;
  logic [3:0] cnt_r;
  logic [vsd_pkg::MEM_AW-1:0] ra_r;
  logic [31:0] w;
  // one read outstanding, nothing taken meanwhile
  assign mem_req_ready = !pend_r && !stall;
  function automatic logic [31:0] peek(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : {12'h5A3, a};
  endfunction
  always @(posedge ref_clk) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      pend_r <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else if (pend_r) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h0) begin
        pend_r <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= peek(ra_r);
      end
    end else if (mem_req_valid && mem_req_ready) begin
      w = peek(mem_addr);
      for (int b = 0; b < 4; b++) begin
        if (mem_be[b]) w[8*b+:8] = mem_wdata[8*b+:8];
      end
      if (mem_write) begin
        mem[mem_addr] = w;
      end else begin
        pend_r <= 1'b1;
        cnt_r <= rd_lat;
        ra_r <= mem_addr;
      end
    end
  end
endmodule

// >>> dv/vsd_slave_bench.sv
`timescale 1ns/1ps
module vsd_slave_bench;
  localparam int FD = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] base_switch_high = 4'h0, base_switch_mid = 4'h8;
  logic [3:0] base_switch_low = 4'hF, loc_be = 4'hF, rd_lat = 4'h2;
  logic slave_port_enable_switch = 1'b0, stall = 1'b0;
  logic a32_mode, bus_req_valid = 1'b0, bus_req_ready, bus_am32 = 1'b1;
  logic bus_write = 1'b0, bus_ack, mem_req_valid, mem_req_ready, mem_write;
  logic [1:0] bus_size = 2'h0;
  logic [31:0] bus_addr = 32'h0000_0000, bus_wdata = 32'h0000_0000;
  logic [31:0] bus_rdata, mem_wdata, mem_rdata, loc_rdata, rd;
  logic [31:0] loc_wdata = 32'h0000_0000;
  logic [19:0] mem_addr, loc_addr = 20'h0_0000;
  logic [3:0] mem_be;
  logic mem_rvalid, loc_req_valid = 1'b0, loc_req_ready, loc_write = 1'b0;
  logic loc_rvalid;
  int miscompares = 0, total_checks = 0, cycles = 0, lat;

  vsd_slave #(.FIFO_DEPTH(FD)) dut_u (.ref_clk, .rst_n, .base_switch_high,
    .base_switch_mid, .base_switch_low, .slave_port_enable_switch,
    .a32_mode, .bus_req_valid, .bus_req_ready, .bus_am32, .bus_write,
    .bus_size, .bus_addr, .bus_wdata, .bus_ack, .bus_rdata, .mem_req_valid,
    .mem_req_ready, .mem_write, .mem_addr, .mem_be, .mem_wdata, .mem_rvalid,
    .mem_rdata, .loc_req_valid, .loc_req_ready, .loc_write, .loc_addr,
    .loc_be, .loc_wdata, .loc_rvalid, .loc_rdata);
  vsd_mem_model mem_u (.ref_clk, .rst_n, .stall, .rd_lat, .mem_req_valid,
    .mem_req_ready, .mem_write, .mem_addr, .mem_be, .mem_wdata, .mem_rvalid,
    .mem_rdata);

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one master cycle; lat = edges from take to ack, 0 if none
  task automatic bus(input logic am, wr, input logic [1:0] sz,
      input logic [31:0] a, d);
    int n;
    n = 0;
    bus_am32 = am;
    bus_write = wr;
    bus_size = sz;
    bus_addr = a;
    bus_wdata = d;
    bus_req_valid = 1'b1;
    @(negedge ref_clk);
    while (bus_req_ready !== 1'b1 && n < 400) begin
      n++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    #1 bus_req_valid = 1'b0;
    lat = 1;
    @(negedge ref_clk);
    while (lat < 40 && bus_ack !== 1'b1) begin
      @(negedge ref_clk);
      lat++;
    end
    if (bus_ack !== 1'b1) lat = 0;
    rd = bus_rdata;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic am, input logic [31:0] a, d);
    bus(am, 1'b1, 2'h0, a, d);
    chk(lat, 1);
  endtask
  task automatic rdc(input logic am, input logic [1:0] sz,
      input logic [31:0] a, e);
    bus(am, 1'b0, sz, a, 32'h0000_0000);
    chk(32'(lat > 0), 1);
    chk(rd, e);
  endtask
  task automatic miss(input logic am, input logic [31:0] a);
    bus(am, 1'b1, 2'h0, a, 32'h0000_0000);
    chk(lat, 0);
  endtask
  task automatic sw(input logic [3:0] h, m, l, input logic off);
    base_switch_high = h;
    base_switch_mid = m;
    base_switch_low = l;
    slave_port_enable_switch = off;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic loc(input logic w, input logic [19:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    loc_write = w;
    loc_addr = a;
    loc_wdata = d;
    loc_req_valid = 1'b1;
    @(negedge ref_clk);
    while (loc_req_ready !== 1'b1 && n < 400) begin
      n++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    #1 loc_req_valid = 1'b0;
    n = 0;
    while (!w && n < 80 && loc_rvalid !== 1'b1) begin
      n++;
      @(negedge ref_clk);
    end
    rd = loc_rdata;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_a32();
    chk(a32_mode, 1);
    wr(1'b1, 32'h0800_0010, 32'h1234_5678);
    rdc(1'b1, 2'h0, 32'h0800_0010, 32'h1234_5678);
    miss(1'b1, 32'h0900_0010);
    miss(1'b0, 32'h0000_0010);
    bus(1'b1, 1'b0, 2'h3, 32'h0800_0010, 32'h0000_0000);
    chk(lat, 0);
    sw(4'hA, 4'h5, 4'hF, 1'b0);
    rdc(1'b1, 2'h0, 32'hA500_0010, 32'h1234_5678);
    miss(1'b1, 32'h0800_0010);
    sw(4'h0, 4'h8, 4'hF, 1'b0);
    $display("test a32 done");
  endtask
  task automatic t_narrow();
    wr(1'b1, 32'h0800_0030, 32'h0000_0000);
    bus(1'b1, 1'b1, 2'h2, 32'h0800_0033, 32'h0000_00AB);
    bus(1'b1, 1'b1, 2'h1, 32'h0800_0030, 32'h0000_BEEF);
    bus(1'b1, 1'b1, 2'h2, 32'h0800_0031, 32'h0000_0012);
    rdc(1'b1, 2'h0, 32'h0800_0030, 32'hBE12_00AB);
    rdc(1'b1, 2'h2, 32'h0800_0030, 32'h0000_00BE);
    rdc(1'b1, 2'h1, 32'h0800_0032, 32'h0000_00AB);
    $display("test narrow done");
  endtask
  task automatic t_swap();
    wr(1'b1, 32'h0840_0020, 32'h1122_3344);
    rdc(1'b1, 2'h0, 32'h0800_0020, 32'h2211_4433);
    rdc(1'b1, 2'h0, 32'h0880_0020, 32'h4433_2211);
    rdc(1'b1, 2'h0, 32'h08C0_0020, 32'h3344_1122);
    wr(1'b1, 32'h08C0_0024, 32'hA1B2_C3D4);
    rdc(1'b1, 2'h0, 32'h0800_0024, 32'hD4C3_B2A1);
    $display("test swap done");
  endtask
  task automatic t_prefetch();
    rd_lat = 4'h8;
    rdc(1'b1, 2'h0, 32'h0800_0200, 32'h5A30_0080);
    chk(32'(lat > 8), 1);
    rdc(1'b1, 2'h0, 32'h0800_0204, 32'h5A30_0081);
    chk(lat, 1);
    rd_lat = 4'h2;
    $display("test prefetch done");
  endtask
  task automatic t_local();
    wr(1'b1, 32'h0800_0400, 32'h600D_F00D);
    loc(1'b0, 20'h0_0100, 32'h0000_0000);
    chk(rd, 32'h600D_F00D);
    rdc(1'b1, 2'h0, 32'h0800_0400, 32'h600D_F00D);
    loc(1'b1, 20'h0_0101, 32'h0BAD_CAFE);
    rdc(1'b1, 2'h0, 32'h0800_0404, 32'h0BAD_CAFE);
    $display("test local done");
  endtask
  task automatic t_fifo();
    int k;
    k = 0;
    stall = 1'b1;
    bus_write = 1'b1;
    bus_size = 2'h0;
    bus_req_valid = 1'b1;
    repeat (30) begin
      bus_addr = 32'h0800_0500 + 32'(4 * k);
      bus_wdata = 32'(k);
      @(negedge ref_clk);
      if (bus_req_ready === 1'b1) k++;
      @(posedge ref_clk);
      #1;
    end
    bus_req_valid = 1'b0;
    chk(k, FD + 1);
    stall = 1'b0;
    rdc(1'b1, 2'h0, 32'h0800_0500 + 32'(4 * (k - 1)), 32'(k - 1));
    $display("test fifo done");
  endtask
  task automatic t_a24();
    sw(4'h3, 4'h9, 4'h1, 1'b0);
    chk(a32_mode, 0);
    wr(1'b0, 32'h0040_0040, 32'hCAFE_0001);
    rdc(1'b0, 2'h0, 32'hFF40_0040, 32'hCAFE_0001);
    miss(1'b0, 32'h0000_0040);
    miss(1'b1, 32'h0940_0040);
    sw(4'hE, 4'h2, 4'h1, 1'b0);
    rdc(1'b0, 2'h0, 32'h0040_0040, 32'hCAFE_0001);
    for (int i = 0; i < 4; i++) begin
      sw(4'hE, 4'h2, 4'(i), 1'b0);
      wr(1'b0, {8'h00, 2'(i), 22'h00_0050}, 32'(i));
      miss(1'b0, {8'h00, 2'(i + 1), 22'h00_0050});
    end
    $display("test a24 done");
  endtask
  task automatic t_off();
    sw(4'h0, 4'h8, 4'hF, 1'b1);
    miss(1'b1, 32'h0800_0010);
    sw(4'h0, 4'h8, 4'hF, 1'b0);
    rdc(1'b1, 2'h0, 32'h0800_0010, 32'h1234_5678);
    $display("test off done");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    t_a32();
    t_narrow();
    t_swap();
    t_prefetch();
    t_local();
    t_fifo();
    t_a24();
    t_off();
    summarize();
  end
endmodule
